// ---- logic/lsc_state_ctrl.sv ----
// Panel and core regulator state-control registers with standby-exit copy
`timescale 1ns/1ns
`default_nettype none

module lsc_state_ctrl
    import lsc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic standby_exit_pin,
    input wire logic panel_oc_raw,
    input wire logic panel_uv_raw,
    input wire logic core_oc_raw,
    input wire logic core_uv_raw,
    output lsc_mode_t panel_mode,
    output logic panel_discharge_en,
    output logic panel_oc_event,
    output logic panel_uv_event,
    output lsc_mode_t core_mode,
    output logic core_discharge_en,
    output logic core_oc_event,
    output logic core_uv_event
);

    typedef struct packed {
        logic [7:0] panel_ctrl;
        logic [7:0] core_ctrl;
        logic [7:0] rdata;
        logic exit_prev;
    } lsc_st_t;

    lsc_st_t st_q;
    lsc_st_t st_d;
    logic exit_rise;
    logic panel_wr;
    logic core_wr;

    // The exit copy uses the exit field as it stood before a same-cycle write,
    // and then overrides only the state field of that write.
    function automatic logic [7:0] lsc_next(input logic [7:0] cur, input logic wr,
                                            input logic [7:0] wdata, input logic exit);
        logic [7:0] v;
        v = cur;
        if (wr) begin
            v = wdata & LSC_WR_MASK;
        end
        if (exit && lsc_code_valid(cur[LSC_EXIT_MSB:LSC_EXIT_LSB])) begin
            v[LSC_STATE_MSB:LSC_STATE_LSB] = cur[LSC_EXIT_MSB:LSC_EXIT_LSB];
        end
        return v;
    endfunction

    // One copy per assertion of the pin, not one per cycle it stays high
    assign exit_rise = standby_exit_pin && !st_q.exit_prev;
    assign panel_wr = reg_wr_en && (reg_addr == LSC_PANEL_ADDR);
    assign core_wr = reg_wr_en && (reg_addr == LSC_CORE_ADDR);

    always_comb begin
        st_d = st_q;
        st_d.exit_prev = standby_exit_pin;
        // Each register only sees its own write strobe
        st_d.panel_ctrl = lsc_next(st_q.panel_ctrl, panel_wr, reg_wdata, exit_rise);
        st_d.core_ctrl = lsc_next(st_q.core_ctrl, core_wr, reg_wdata, exit_rise);
        if (reg_rd_en) begin
            case (reg_addr)
                LSC_PANEL_ADDR: st_d.rdata = st_q.panel_ctrl;
                LSC_CORE_ADDR: st_d.rdata = st_q.core_ctrl;
                default: st_d.rdata = LSC_RD_NONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= '{panel_ctrl: LSC_PANEL_RST, core_ctrl: LSC_CORE_RST,
                      rdata: LSC_RD_NONE, exit_prev: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;

    lsc_chan u_panel (
        .clk(clk),
        .resetn(resetn),
        .state_code(st_q.panel_ctrl[LSC_STATE_MSB:LSC_STATE_LSB]),
        .oc_raw(panel_oc_raw),
        .uv_raw(panel_uv_raw),
        .mode(panel_mode),
        .discharge_en(panel_discharge_en),
        .oc_event(panel_oc_event),
        .uv_event(panel_uv_event)
    );

    lsc_chan u_core (
        .clk(clk),
        .resetn(resetn),
        .state_code(st_q.core_ctrl[LSC_STATE_MSB:LSC_STATE_LSB]),
        .oc_raw(core_oc_raw),
        .uv_raw(core_uv_raw),
        .mode(core_mode),
        .discharge_en(core_discharge_en),
        .oc_event(core_oc_event),
        .uv_event(core_uv_event)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Register bank: reset values, writes, reads and reserved bits
    reset_values_a: assert property ($rose(resetn) |->
        st_q.panel_ctrl == 8'h24 && st_q.core_ctrl == 8'h07)
        else $error("control registers not at reset values");
    panel_write_a: assert property (panel_wr && !exit_rise |=>
        st_q.panel_ctrl == ($past(reg_wdata) & 8'h3f))
        else $error("panel write not stored");
    core_write_a: assert property (core_wr && !exit_rise |=>
        st_q.core_ctrl == ($past(reg_wdata) & 8'h3f))
        else $error("core write not stored");
    panel_read_a: assert property (reg_rd_en && reg_addr == 8'h46 |=>
        reg_rdata == $past(st_q.panel_ctrl))
        else $error("panel read returned wrong value");
    core_read_a: assert property (reg_rd_en && reg_addr == 8'h41 |=>
        reg_rdata == $past(st_q.core_ctrl))
        else $error("core read returned wrong value");
    read_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    reserved_zero_a: assert property (st_q.panel_ctrl[7:6] == 2'b00 &&
        st_q.core_ctrl[7:6] == 2'b00)
        else $error("reserved bits not zero");

    // Standby exit: copy on a valid exit code, nothing on codes 0 to 3
    panel_exit_copy_a: assert property (exit_rise && !panel_wr && st_q.panel_ctrl[5]
        |=> st_q.panel_ctrl[2:0] == $past(st_q.panel_ctrl[5:3]))
        else $error("panel exit state not copied");
    core_exit_copy_a: assert property (exit_rise && !core_wr && st_q.core_ctrl[5]
        |=> st_q.core_ctrl[2:0] == $past(st_q.core_ctrl[5:3]))
        else $error("core exit state not copied");
    panel_no_copy_a: assert property (exit_rise && !panel_wr && !st_q.panel_ctrl[5]
        |=> $stable(st_q.panel_ctrl))
        else $error("panel state changed on a do-not-copy exit");
    core_no_copy_a: assert property (exit_rise && !core_wr && !st_q.core_ctrl[5]
        |=> $stable(st_q.core_ctrl))
        else $error("core state changed on a do-not-copy exit");
    panel_exit_kept_a: assert property (exit_rise && !panel_wr |=>
        st_q.panel_ctrl[5:3] == $past(st_q.panel_ctrl[5:3]))
        else $error("panel exit field lost on copy");
    core_exit_kept_a: assert property (exit_rise && !core_wr |=>
        st_q.core_ctrl[5:3] == $past(st_q.core_ctrl[5:3]))
        else $error("core exit field lost on copy");

    // Outside an exit, each regulator only moves on its own strobe
    independent_a: assert property (core_wr && !exit_rise |=> $stable(st_q.panel_ctrl))
        else $error("core write disturbed panel register");
    core_untouched_a: assert property (panel_wr && !exit_rise |=>
        $stable(st_q.core_ctrl))
        else $error("panel write disturbed core register");

    // Mode decode and output discharge, one cycle behind the register
    discharge_off_a: assert property (st_q.core_ctrl[2:0] == 3'h4 |=>
        core_discharge_en && core_mode == LSC_MODE_OFF)
        else $error("off regulator not discharged");
    panel_discharge_a: assert property (st_q.panel_ctrl[2:0] == LSC_CODE_OFF |=>
        panel_discharge_en && panel_mode == LSC_MODE_OFF)
        else $error("off panel regulator not discharged");
    active_mode_a: assert property (st_q.panel_ctrl[2:1] == 2'b11 |=>
        panel_mode == LSC_MODE_ACTIVE && !panel_discharge_en)
        else $error("active code not decoded");
    core_active_a: assert property (st_q.core_ctrl[2:1] == 2'b11 |=>
        core_mode == LSC_MODE_ACTIVE && !core_discharge_en)
        else $error("core active code not decoded");
    low_mode_a: assert property (st_q.panel_ctrl[2:0] == LSC_CODE_LOW |=>
        panel_mode == LSC_MODE_LOW && !panel_discharge_en)
        else $error("low-power code not decoded");
    reserved_off_a: assert property (!st_q.panel_ctrl[2] |=>
        panel_mode == LSC_MODE_OFF && panel_discharge_en)
        else $error("reserved code did not leave regulator off");

    // Fault events: one pulse per rising fault level, silent while off
    oc_event_a: assert property ($rose(core_oc_raw) && core_mode != LSC_MODE_OFF |=>
        core_oc_event ##1 !core_oc_event)
        else $error("over-current event not one pulse");
    core_uv_a: assert property ($rose(core_uv_raw) && core_mode != LSC_MODE_OFF |=>
        core_uv_event ##1 !core_uv_event)
        else $error("core under-voltage event not one pulse");
    panel_oc_a: assert property ($rose(panel_oc_raw) && panel_mode != LSC_MODE_OFF |=>
        panel_oc_event ##1 !panel_oc_event)
        else $error("panel over-current event not one pulse");
    panel_uv_a: assert property ($rose(panel_uv_raw) && panel_mode != LSC_MODE_OFF |=>
        panel_uv_event ##1 !panel_uv_event)
        else $error("panel under-voltage event not one pulse");
    core_quiet_a: assert property (core_mode == LSC_MODE_OFF |=>
        !core_oc_event && !core_uv_event)
        else $error("event reported while core regulator off");
    panel_quiet_a: assert property (panel_mode == LSC_MODE_OFF |=>
        !panel_oc_event && !panel_uv_event)
        else $error("event reported while panel regulator off");

    exit_copy_c: cover property (exit_rise && st_q.panel_ctrl[5] && st_q.core_ctrl[5]);
    low_power_c: cover property (panel_mode == LSC_MODE_LOW ##1 panel_mode == LSC_MODE_OFF);
    uv_event_c: cover property (panel_uv_event);
    core_wake_c: cover property (core_mode == LSC_MODE_OFF ##1 core_mode == LSC_MODE_ACTIVE);
    no_copy_c: cover property (exit_rise && !st_q.panel_ctrl[5]);

endmodule

`default_nettype wire

// ---- logic/lsc_pkg.sv ----
// Shared constants, types and helpers for the regulator state-control block
package lsc_pkg;

    localparam logic [7:0] LSC_CORE_ADDR = 8'h41;
    localparam logic [7:0] LSC_PANEL_ADDR = 8'h46;
    localparam logic [7:0] LSC_CORE_RST = 8'h07;
    localparam logic [7:0] LSC_PANEL_RST = 8'h24;
    localparam logic [7:0] LSC_WR_MASK = 8'h3f;
    localparam logic [7:0] LSC_RD_NONE = 8'h00;
    localparam int LSC_STATE_LSB = 0;
    localparam int LSC_STATE_MSB = 2;
    localparam int LSC_EXIT_LSB = 3;
    localparam int LSC_EXIT_MSB = 5;
    localparam logic [2:0] LSC_CODE_OFF = 3'h4;
    localparam logic [2:0] LSC_CODE_LOW = 3'h5;

    typedef enum logic [1:0] {
        LSC_MODE_OFF,
        LSC_MODE_LOW,
        LSC_MODE_ACTIVE
    } lsc_mode_t;

    // Codes 0 to 3 are reserved; they drive the regulator off as the safe choice
    function automatic lsc_mode_t lsc_decode(input logic [2:0] code);
        lsc_mode_t m;
        m = LSC_MODE_OFF;
        if (code == LSC_CODE_LOW) begin
            m = LSC_MODE_LOW;
        end else if (code[2] && code[1]) begin
            m = LSC_MODE_ACTIVE;
        end
        return m;
    endfunction

    // Exit codes 4 to 7 are real states; 0 to 3 mean do not copy
    function automatic logic lsc_code_valid(input logic [2:0] code);
        return code[2];
    endfunction

endpackage

// ---- logic/lsc_chan.sv ----
// One regulator channel: mode decode, output discharge and fault events
`timescale 1ns/1ns
`default_nettype none

module lsc_chan
    import lsc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] state_code,
    input wire logic oc_raw,
    input wire logic uv_raw,
    output lsc_mode_t mode,
    output logic discharge_en,
    output logic oc_event,
    output logic uv_event
);

    typedef struct packed {
        lsc_mode_t mode;
        logic dis;
        logic oc_prev;
        logic uv_prev;
        logic oc_evt;
        logic uv_evt;
    } lsc_chan_st_t;

    lsc_chan_st_t st_q;
    lsc_chan_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.mode = lsc_decode(state_code);
        st_d.dis = (lsc_decode(state_code) == LSC_MODE_OFF);
        st_d.oc_prev = oc_raw;
        st_d.uv_prev = uv_raw;
        // Faults on a regulator that is off are expected and not reported
        st_d.oc_evt = oc_raw && !st_q.oc_prev && (st_q.mode != LSC_MODE_OFF);
        st_d.uv_evt = uv_raw && !st_q.uv_prev && (st_q.mode != LSC_MODE_OFF);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= '{mode: LSC_MODE_OFF, dis: 1'b1, oc_prev: 1'b0, uv_prev: 1'b0,
                      oc_evt: 1'b0, uv_evt: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign mode = st_q.mode;
    assign discharge_en = st_q.dis;
    assign oc_event = st_q.oc_evt;
    assign uv_event = st_q.uv_evt;

endmodule

`default_nettype wire

// ---- dv/lsc_host.sv ----
// Host model: register strobes and the standby-exit pin
`timescale 1ns/1ns
`default_nettype none
module lsc_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic exit_pin
);
    initial {wr_en, rd_en, exit_pin, addr, wdata} = '0;
    // Released lines show the inverse so a stale value is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task automatic pulse_exit();
        @(posedge clk);
        exit_pin <= 1'b1;
        @(posedge clk);
        exit_pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/lsc_state_ctrl_bench.sv ----
// Self-checking bench for the regulator state-control block
`timescale 1ns/1ns
`default_nettype none
module lsc_state_ctrl_bench;
    import lsc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wr_en, rd_en, exit_pin, pd, cd, poe, pue, coe, cue;
    logic [7:0] addr, wdata, rdata, rv, st, ev;
    logic [3:0] raw = 4'h0;
    lsc_mode_t pm, cm;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    assign st = {2'h0, cm, cd, pm, pd};
    assign ev = {4'h0, poe, pue, coe, cue};
    always #10 clk = ~clk;
    lsc_host host (.clk(clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .exit_pin(exit_pin));
    lsc_state_ctrl dut (.clk(clk), .resetn(resetn), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .standby_exit_pin(exit_pin),
        .panel_oc_raw(raw[3]), .panel_uv_raw(raw[2]), .core_oc_raw(raw[1]),
        .core_uv_raw(raw[0]), .panel_mode(pm), .panel_discharge_en(pd),
        .panel_oc_event(poe), .panel_uv_event(pue), .core_mode(cm),
        .core_discharge_en(cd), .core_oc_event(coe), .core_uv_event(cue));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t register read %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_state(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t mode and discharge %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_evt(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t fault events %h exp %h", $time, got, exp);
        end
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic t_reset();
        host.rd(LSC_PANEL_ADDR, rv);
        chk_reg(rv, 8'h24);
        host.rd(LSC_CORE_ADDR, rv);
        chk_reg(rv, 8'h07);
        host.rd(8'h42, rv);
        chk_reg(rv, 8'h00);
        chk_state(st, {2'h0, LSC_MODE_ACTIVE, 1'b0, LSC_MODE_OFF, 1'b1});
        $display("test reset done");
    endtask
    task automatic t_codes();
        lsc_mode_t em;
        for (int c = 0; c < 8; c++) begin
            em = LSC_MODE_OFF;
            if (c == 5) begin
                em = LSC_MODE_LOW;
            end else if (c >= 6) begin
                em = LSC_MODE_ACTIVE;
            end
            host.wr(LSC_PANEL_ADDR, {5'h1f, c[2:0]});
            repeat (2) @(posedge clk);
            #1;
            chk_state(st, {2'h0, LSC_MODE_ACTIVE, 1'b0, em, em == LSC_MODE_OFF});
        end
        host.rd(LSC_PANEL_ADDR, rv);
        chk_reg(rv, 8'h3f);
        host.rd(LSC_CORE_ADDR, rv);
        chk_reg(rv, 8'h07);
        $display("test codes done");
    endtask
    task automatic t_exit();
        host.wr(LSC_PANEL_ADDR, 8'h2c);
        host.wr(LSC_CORE_ADDR, 8'h0e);
        host.pulse_exit();
        repeat (2) @(posedge clk);
        #1;
        chk_state(st, {2'h0, LSC_MODE_ACTIVE, 1'b0, LSC_MODE_LOW, 1'b0});
        host.rd(LSC_PANEL_ADDR, rv);
        chk_reg(rv, 8'h2d);
        host.rd(LSC_CORE_ADDR, rv);
        chk_reg(rv, 8'h0e);
        $display("test exit done");
    endtask
    task automatic t_fault();
        @(posedge clk);
        raw <= 4'hf;
        @(posedge clk);
        #1;
        chk_evt(ev[3:0], 4'hf);
        @(posedge clk);
        #1;
        chk_evt(ev[3:0], 4'h0);
        @(posedge clk);
        raw <= 4'h0;
        // Panel off: its monitors must stay quiet while the core still reports
        host.wr(LSC_PANEL_ADDR, 8'h24);
        repeat (2) @(posedge clk);
        raw <= 4'hf;
        @(posedge clk);
        #1;
        chk_evt(ev[3:0], 4'h3);
        @(posedge clk);
        raw <= 4'h0;
        $display("test fault done");
    endtask
    task automatic t_core_off();
        // Core off with exit code active; panel already off with exit code off
        host.wr(LSC_CORE_ADDR, 8'h3c);
        repeat (2) @(posedge clk);
        #1;
        chk_state(st, {2'h0, LSC_MODE_OFF, 1'b1, LSC_MODE_OFF, 1'b1});
        @(posedge clk);
        raw <= 4'hf;
        @(posedge clk);
        #1;
        chk_evt(ev[3:0], 4'h0);
        @(posedge clk);
        raw <= 4'h0;
        host.pulse_exit();
        repeat (2) @(posedge clk);
        #1;
        chk_state(st, {2'h0, LSC_MODE_ACTIVE, 1'b0, LSC_MODE_OFF, 1'b1});
        host.rd(LSC_CORE_ADDR, rv);
        chk_reg(rv, 8'h3f);
        host.rd(LSC_PANEL_ADDR, rv);
        chk_reg(rv, 8'h24);
        $display("test core off done");
    endtask
    task automatic t_rereset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        host.rd(LSC_PANEL_ADDR, rv);
        chk_reg(rv, 8'h24);
        host.rd(LSC_CORE_ADDR, rv);
        chk_reg(rv, 8'h07);
        // Panel low power with a do-not-copy exit code must survive the exit pin
        host.wr(LSC_PANEL_ADDR, 8'h05);
        host.pulse_exit();
        host.rd(LSC_PANEL_ADDR, rv);
        chk_reg(rv, 8'h05);
        host.rd(LSC_CORE_ADDR, rv);
        chk_reg(rv, 8'h07);
        chk_state(st, {2'h0, LSC_MODE_ACTIVE, 1'b0, LSC_MODE_LOW, 1'b0});
        $display("test mid-run reset done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_codes();
        t_exit();
        t_fault();
        t_core_off();
        t_rereset();
        print_verdict();
    end
endmodule
`default_nettype wire
